/* gtp_consts.svh */
`ifndef GTP_CONSTS_SVH
`define GTP_CONSTS_SVH
`define GTP_NT 5
`define GTP_W 16
`define GTP_AW 4
`define GTP_PREW 10
`define GTP_SW 8
`define GTP_CAPW 5
`define GTP_AUXA 0
`define GTP_CORE1 1
`define GTP_AUXB 2
`define GTP_AUX2 3
`define GTP_CORE2 4
`define GTP_PRE1_BASE 4'h3
`define GTP_PRE2_BASE 4'h2
`define GTP_A_CTL 4'h0
`define GTP_A_CNT 4'h5
`define GTP_A_CAPTURE_RELOAD_REG 4'ha
`define GTP_A_CAPCTL 4'hb
`define GTP_A_STAT 4'hc
`define GTP_A_MASK 4'hd
`define GTP_F_SEL 2:0
`define GTP_F_MODE 5:3
`define GTP_B_RUN 6
`define GTP_B_DOWN 7
`define GTP_B_EXTDIR 8
`define GTP_B_OUTEN 9
`define GTP_B_RLDEN 10
`define GTP_M_TIMER 3'h0
`define GTP_M_COUNT 3'h1
`define GTP_M_GATELO 3'h2
`define GTP_M_GATEHI 3'h3
`define GTP_M_RELOAD 3'h4
`define GTP_M_CAPT 3'h5
`define GTP_M_INCR 3'h6
`define GTP_SEL_LATRISE 3'h4
`define GTP_SEL_LATFALL 3'h5
`define GTP_F_CAPEDGE 1:0
`define GTP_B_CAPCLR 2
`define GTP_B_CAPCNT 3
`define GTP_B_CAPDIR 4
`define GTP_ZERO 16'h0000
`define GTP_ONES 16'hffff
`endif

/* gtp_pkg.sv */
`include "gtp_consts.svh"
package gtp_pkg;
  typedef struct packed {
    logic [`GTP_NT-1:0][`GTP_W-1:0] ctl;
    logic [`GTP_NT-1:0][`GTP_W-1:0] cnt;
    logic [`GTP_W-1:0] capture_reload_reg;
    logic [`GTP_CAPW-1:0] capctl;
    logic [`GTP_SW-1:0] status;
    logic [`GTP_SW-1:0] mask;
    logic [`GTP_PREW-1:0] pre;
    logic [`GTP_NT-1:0] pin_d;
    logic [`GTP_NT-1:0] dir_d;
    logic cap_d;
    logic lat1;
    logic lat1_d;
    logic lat2;
    logic lat2_d;
    logic ovf2;
    logic [`GTP_W-1:0] rdata;
  } gtp_state_t;
endpackage

/* gtp_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// quadrature position sensor: one gray step per request
module gtp_sensor_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // step request from the bench
  input wire logic i_step,
  input wire logic i_rev,
  // sensor tracks
  output logic o_a,
  output logic o_b
);
  logic [1:0] phase;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      phase <= 2'h0;
    end else if (i_step) begin
      phase <= i_rev ? phase - 2'h1 : phase + 2'h1;
    end
  end
  // gray order keeps one track moving per step, as a real encoder does
  assign o_a = phase[1];
  assign o_b = phase[1] ^ phase[0];
endmodule
`default_nettype wire

/* gtp_timer_pair.sv */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "gtp_consts.svh"
// Functional notes
// - each first-module timer: timer, gated, counter or quadrature mode
// - first-module prescaler code 0 divides by 8, doubling up to 1024
// - counter mode counts selected edges of the timer's own pin
// - gated mode counts prescaled ticks only while gate is active
// - one pin per timer serves as gate or count input
// - direction set by software, optionally flipped by direction pin
// - quadrature mode derives count and direction from A and B pins
// - first core over/underflow toggles latch; pin or aux clock
// - aux timers in reload or capture configuration stop counting
// - capture: aux pin edge copies first core value into aux
// - reload: core loaded from aux on pin edge or latch edge
// - opposite latch edge reloads from two auxes give continuous pwm
// - second-module prescaler code 0 divides by 4, doubling up to 512
// - second core over/underflow toggles latch; pin or aux clock
// - second core over/underflow is exported and reloads from capreg
// - capture pin edge copies second aux into capreg, optional clear
// - capture may also fire on first core count or direction edges
// - all five timers are 16 bits, concatenable within module
module gtp_timer_pair (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [`GTP_AW-1:0] i_addr,
  input wire logic [`GTP_W-1:0] i_wdata,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [`GTP_W-1:0] o_rdata,
  // timer pins
  input wire logic [`GTP_NT-1:0] i_timer_gate_count_pin,
  input wire logic [`GTP_NT-1:0] i_timer_direction_pin,
  input wire logic i_capture_trigger_pin,
  // outputs
  output logic o_toggle_output_pin,
  output logic o_second_toggle_output_pin,
  output logic o_second_core_ovf,
  output logic o_irq
);

  gtp_pkg::gtp_state_t st;
  gtp_pkg::gtp_state_t next_st;
  logic [`GTP_NT-1:0] tick;
  logic [`GTP_NT-1:0] en;
  logic [`GTP_NT-1:0] pe;
  logic [`GTP_NT-1:0] rld;
  logic [`GTP_NT-1:0] capt;
  logic [`GTP_NT-1:0] ovf;
  logic [`GTP_NT-1:0][2:0] md;
  logic [`GTP_NT-1:0][2:0] sel;
  logic [`GTP_NT-1:0][`GTP_W-1:0] cval;
  logic lat1_rise;
  logic lat1_fall;
  logic lat1_edge;
  logic lat2_edge;
  logic cap_ev;
  logic cap_rise;
  logic cap_fall;
  logic [`GTP_SW-1:0] set_st;
  logic [2:0] aidx;
  logic stat_rd;

  // latch edges are seen one cycle late, from the registered copy
  assign lat1_rise = st.lat1 & ~st.lat1_d;
  assign lat1_fall = ~st.lat1 & st.lat1_d;
  assign lat1_edge = st.lat1 ^ st.lat1_d;
  assign lat2_edge = st.lat2 ^ st.lat2_d;

  genvar g;
  generate
    for (g = 0; g < `GTP_NT; g++) begin : tmr
      localparam logic [3:0] PB = (g < `GTP_AUX2) ?
                                  `GTP_PRE1_BASE : `GTP_PRE2_BASE;
      localparam bit AUX = (g != `GTP_CORE1) && (g != `GTP_CORE2);
      localparam bit AUX1 = (g == `GTP_AUXA) || (g == `GTP_AUXB);
      logic [3:0] sh;
      logic [`GTP_PREW-1:0] pmask;
      logic pin;
      logic rise;
      logic fall;
      logic dchg;
      logic lat_edge;
      logic cnt_en;
      logic dir_up;

      assign sel[g] = st.ctl[g][`GTP_F_SEL];
      assign md[g] = st.ctl[g][`GTP_F_MODE];
      // shared free-running prescaler, one tick per 2^(code+base)
      assign sh = {1'b0, sel[g]} + PB;
      assign pmask = ~({`GTP_PREW{1'b1}} << sh);
      assign tick[g] = &(st.pre | ~pmask);
      assign pin = i_timer_gate_count_pin[g];
      assign rise = pin & ~st.pin_d[g];
      assign fall = ~pin & st.pin_d[g];
      assign dchg = i_timer_direction_pin[g] ^ st.dir_d[g];
      assign pe[g] = (sel[g][0] & rise) | (sel[g][1] & fall);
      assign lat_edge = (g == `GTP_AUX2) ? lat2_edge : lat1_edge;

      always_comb begin
        unique case (md[g])
          `GTP_M_TIMER: cnt_en = tick[g];
          // aux clocked by core latch chains the pair
          `GTP_M_COUNT: cnt_en = (AUX && sel[g][2]) ?
                                 lat_edge : pe[g];
          `GTP_M_GATELO: cnt_en = tick[g] & ~pin;
          `GTP_M_GATEHI: cnt_en = tick[g] & pin;
          `GTP_M_INCR: cnt_en = (pin ^ st.pin_d[g]) | dchg;
          // reload and capture configurations hold the count
          default: cnt_en = 1'b0;
        endcase
      end

      assign en[g] = cnt_en & st.ctl[g][`GTP_B_RUN];
      // quadrature: b leading a counts up
      assign dir_up = (md[g] == `GTP_M_INCR) ?
                      (st.pin_d[g] ^ i_timer_direction_pin[g]) :
                      ~(st.ctl[g][`GTP_B_DOWN] ^
                        (st.ctl[g][`GTP_B_EXTDIR] &
                         i_timer_direction_pin[g]));
      assign ovf[g] = en[g] & (dir_up ? (st.cnt[g] == `GTP_ONES) :
                                        (st.cnt[g] == `GTP_ZERO));
      assign cval[g] = !en[g] ? st.cnt[g] :
                       dir_up ? st.cnt[g] + `GTP_W'(1) :
                                st.cnt[g] - `GTP_W'(1);
      assign rld[g] = AUX1 && (md[g] == `GTP_M_RELOAD) &&
                      (sel[g][2] ? (sel[g][0] ? lat1_fall : lat1_rise) :
                                   pe[g]);
      assign capt[g] = AUX1 && (md[g] == `GTP_M_CAPT) && pe[g];
    end
  endgenerate

  assign cap_rise = i_capture_trigger_pin & ~st.cap_d;
  assign cap_fall = ~i_capture_trigger_pin & st.cap_d;
  assign cap_ev = (st.capctl[0] & cap_rise) | (st.capctl[1] & cap_fall) |
                  (st.capctl[`GTP_B_CAPCNT] &
                   (i_timer_gate_count_pin[`GTP_CORE1] ^
                    st.pin_d[`GTP_CORE1])) |
                  (st.capctl[`GTP_B_CAPDIR] &
                   (i_timer_direction_pin[`GTP_CORE1] ^
                    st.dir_d[`GTP_CORE1]));
  assign set_st = {cap_ev, capt[`GTP_AUXB], capt[`GTP_AUXA], ovf};
  assign aidx = 3'(i_addr - `GTP_A_CNT);
  assign stat_rd = i_rd_en && (i_addr == `GTP_A_STAT);

  always_comb begin
    next_st = st;
    next_st.pre = st.pre + `GTP_PREW'(1);
    next_st.pin_d = i_timer_gate_count_pin;
    next_st.dir_d = i_timer_direction_pin;
    next_st.cap_d = i_capture_trigger_pin;
    next_st.lat1_d = st.lat1;
    next_st.lat2_d = st.lat2;
    next_st.cnt = cval;
    next_st.ovf2 = ovf[`GTP_CORE2];
    if (ovf[`GTP_CORE1]) begin
      next_st.lat1 = ~st.lat1;
    end
    if (ovf[`GTP_CORE2]) begin
      next_st.lat2 = ~st.lat2;
    end
    if (ovf[`GTP_CORE2] && st.ctl[`GTP_CORE2][`GTP_B_RLDEN]) begin
      next_st.cnt[`GTP_CORE2] = st.capture_reload_reg;
    end
    // aux b wins if both reload in one cycle; pwm setups never collide
    if (rld[`GTP_AUXA]) begin
      next_st.cnt[`GTP_CORE1] = st.cnt[`GTP_AUXA];
    end
    if (rld[`GTP_AUXB]) begin
      next_st.cnt[`GTP_CORE1] = st.cnt[`GTP_AUXB];
    end
    if (capt[`GTP_AUXA]) begin
      next_st.cnt[`GTP_AUXA] = st.cnt[`GTP_CORE1];
    end
    if (capt[`GTP_AUXB]) begin
      next_st.cnt[`GTP_AUXB] = st.cnt[`GTP_CORE1];
    end
    if (cap_ev) begin
      next_st.capture_reload_reg = st.cnt[`GTP_AUX2];
      if (st.capctl[`GTP_B_CAPCLR]) begin
        next_st.cnt[`GTP_AUX2] = `GTP_ZERO;
      end
    end
    // a new event beats the read-clear
    next_st.status = (st.status & ~{`GTP_SW{stat_rd}}) | set_st;
    // software write overrides any hardware update
    if (i_wr_en) begin
      if (i_addr < `GTP_A_CNT) begin
        next_st.ctl[i_addr[2:0]] = i_wdata;
      end else if (i_addr < `GTP_A_CAPTURE_RELOAD_REG) begin
        next_st.cnt[aidx] = i_wdata;
      end else begin
        case (i_addr)
          `GTP_A_CAPTURE_RELOAD_REG: next_st.capture_reload_reg = i_wdata;
          `GTP_A_CAPCTL: next_st.capctl = i_wdata[`GTP_CAPW-1:0];
          `GTP_A_MASK: next_st.mask = i_wdata[`GTP_SW-1:0];
          default: ;
        endcase
      end
    end
    next_st.rdata = `GTP_ZERO;
    if (i_rd_en) begin
      if (i_addr < `GTP_A_CNT) begin
        next_st.rdata = st.ctl[i_addr[2:0]];
      end else if (i_addr < `GTP_A_CAPTURE_RELOAD_REG) begin
        next_st.rdata = st.cnt[aidx];
      end else begin
        case (i_addr)
          `GTP_A_CAPTURE_RELOAD_REG: next_st.rdata = st.capture_reload_reg;
          `GTP_A_CAPCTL: next_st.rdata = `GTP_W'(st.capctl);
          `GTP_A_STAT: next_st.rdata = `GTP_W'(st.status);
          `GTP_A_MASK: next_st.rdata = `GTP_W'(st.mask);
          default: next_st.rdata = `GTP_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_toggle_output_pin = st.lat1 &
                               st.ctl[`GTP_CORE1][`GTP_B_OUTEN];
  assign o_second_toggle_output_pin = st.lat2 &
                               st.ctl[`GTP_CORE2][`GTP_B_OUTEN];
  assign o_second_core_ovf = st.ovf2;
  assign o_irq = |(st.status & st.mask);

  core_toggle_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.lat1 != st.lat1_d) |-> $past(ovf[`GTP_CORE1]))
    else $error("first core latch changed without wrap");

  second_toggle_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    ovf[`GTP_CORE2] |=> (st.lat2 != $past(st.lat2)) && o_second_core_ovf)
    else $error("second core latch did not toggle on wrap");

  aux_stop_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_AUXA] == `GTP_M_RELOAD && !i_wr_en) |=>
      st.cnt[`GTP_AUXA] == $past(st.cnt[`GTP_AUXA]))
    else $error("aux timer counted in reload configuration");

  capture_copy_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (capt[`GTP_AUXA] && !i_wr_en) |=>
      st.cnt[`GTP_AUXA] == $past(st.cnt[`GTP_CORE1]))
    else $error("capture did not copy core value");

  reload_copy_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (rld[`GTP_AUXB] && !i_wr_en) |=>
      st.cnt[`GTP_CORE1] == $past(st.cnt[`GTP_AUXB]))
    else $error("core not reloaded from aux");

  pwm_alternate_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_AUXA] == `GTP_M_RELOAD && sel[`GTP_AUXA] == `GTP_SEL_LATRISE &&
     md[`GTP_AUXB] == `GTP_M_RELOAD && sel[`GTP_AUXB] == `GTP_SEL_LATFALL &&
     lat1_rise && !i_wr_en) |=>
      st.cnt[`GTP_CORE1] == $past(st.cnt[`GTP_AUXA]))
    else $error("pwm rising half not loaded from aux a");

  prescale_one_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    tick[`GTP_CORE1] |=> !tick[`GTP_CORE1] [*7])
    else $error("first module tick faster than eight cycles");

  prescale_two_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    tick[`GTP_CORE2] |=> !tick[`GTP_CORE2] [*3])
    else $error("second module tick faster than four cycles");

  gate_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_AUXA] == `GTP_M_GATEHI &&
     !i_timer_gate_count_pin[`GTP_AUXA] && !i_wr_en) |=>
      st.cnt[`GTP_AUXA] == $past(st.cnt[`GTP_AUXA]))
    else $error("gated timer counted with gate closed");

  capture_reload_reg_copy_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (cap_ev && !i_wr_en) |=> st.capture_reload_reg == $past(st.cnt[`GTP_AUX2]))
    else $error("capture register missed second aux value");

  core2_reload_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (ovf[`GTP_CORE2] && st.ctl[`GTP_CORE2][`GTP_B_RLDEN] && !i_wr_en) |=>
      st.cnt[`GTP_CORE2] == $past(st.capture_reload_reg))
    else $error("second core not reloaded on wrap");

  wrap_value_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (ovf[`GTP_CORE1] && !rld[`GTP_AUXA] && !rld[`GTP_AUXB] && !i_wr_en) |=>
      (st.cnt[`GTP_CORE1] == `GTP_ZERO || st.cnt[`GTP_CORE1] == `GTP_ONES))
    else $error("wrap flagged away from boundary");

  count_edge_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_CORE1] == `GTP_M_COUNT && pe[`GTP_CORE1] &&
     st.ctl[`GTP_CORE1][`GTP_B_RUN] &&
     !rld[`GTP_AUXA] && !rld[`GTP_AUXB] && !i_wr_en) |=>
      st.cnt[`GTP_CORE1] != $past(st.cnt[`GTP_CORE1]))
    else $error("counter missed a pin edge");

  capture_stop_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_AUXA] == `GTP_M_CAPT && !capt[`GTP_AUXA] && !i_wr_en) |=>
      st.cnt[`GTP_AUXA] == $past(st.cnt[`GTP_AUXA]))
    else $error("aux timer counted in capture configuration");

  aux_b_stop_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_AUXB] == `GTP_M_RELOAD && !i_wr_en) |=>
      st.cnt[`GTP_AUXB] == $past(st.cnt[`GTP_AUXB]))
    else $error("aux b counted in reload configuration");

  aux_a_reload_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (rld[`GTP_AUXA] && !rld[`GTP_AUXB] && !i_wr_en) |=>
      st.cnt[`GTP_CORE1] == $past(st.cnt[`GTP_AUXA]))
    else $error("core not reloaded from aux a");

  chain_count_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_AUX2] == `GTP_M_COUNT && sel[`GTP_AUX2][2] &&
     st.ctl[`GTP_AUX2][`GTP_B_RUN] && lat2_edge && !cap_ev && !i_wr_en) |=>
      st.cnt[`GTP_AUX2] != $past(st.cnt[`GTP_AUX2]))
    else $error("chained aux missed a latch edge");

  quad_step_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_CORE1] == `GTP_M_INCR && st.ctl[`GTP_CORE1][`GTP_B_RUN] &&
     (i_timer_gate_count_pin[`GTP_CORE1] != st.pin_d[`GTP_CORE1]) &&
     !rld[`GTP_AUXA] && !rld[`GTP_AUXB] && !i_wr_en) |=>
      st.cnt[`GTP_CORE1] != $past(st.cnt[`GTP_CORE1]))
    else $error("quadrature track edge not counted");

  ext_dir_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (en[`GTP_AUXA] && md[`GTP_AUXA] != `GTP_M_INCR &&
     (st.ctl[`GTP_AUXA][`GTP_B_DOWN] ^
      (st.ctl[`GTP_AUXA][`GTP_B_EXTDIR] &
       i_timer_direction_pin[`GTP_AUXA])) && !i_wr_en) |=>
      st.cnt[`GTP_AUXA] == $past(st.cnt[`GTP_AUXA]) - `GTP_W'(1))
    else $error("aux a did not count down as selected");

  gate_low_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (md[`GTP_AUXA] == `GTP_M_GATELO &&
     i_timer_gate_count_pin[`GTP_AUXA] && !i_wr_en) |=>
      st.cnt[`GTP_AUXA] == $past(st.cnt[`GTP_AUXA]))
    else $error("low gated timer counted with gate closed");

  capture_clear_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (cap_ev && st.capctl[`GTP_B_CAPCLR] && !i_wr_en) |=>
      st.cnt[`GTP_AUX2] == `GTP_ZERO)
    else $error("second aux not cleared after capture");

  pin_capture_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.capctl[`GTP_B_CAPCNT] &&
     (i_timer_gate_count_pin[`GTP_CORE1] != st.pin_d[`GTP_CORE1])) |->
      cap_ev)
    else $error("core pin change did not trigger capture");

  wrap_flag_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    ovf[`GTP_CORE1] |=> st.status[`GTP_CORE1])
    else $error("core wrap flag not set");

endmodule
`default_nettype wire

/* tb_gtp_timer_pair.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gtp_consts.svh"
module tb_gtp_timer_pair;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [4:0] gc = 5'h00;
  logic [4:0] dp = 5'h00;
  logic cap = 1'b0;
  logic step = 1'b0;
  logic rev = 1'b0;
  logic sens_a;
  logic sens_b;
  logic [15:0] o_rdata;
  logic o_toggle_output_pin;
  logic o_second_toggle_output_pin;
  logic o_second_core_ovf;
  logic o_irq;
  logic [15:0] v;
  logic [15:0] r [4];
  logic seen_ovf;
  int n_fail = 0;
  int checked = 0;
  int hi = 0;
  // first core pins carry the sensor tracks merged with the bench bits
  wire [4:0] gate_pins = {gc[4:2], gc[1] ^ sens_a, gc[0]};
  wire [4:0] dir_pins = {dp[4:2], dp[1] ^ sens_b, dp[0]};

  always #5 i_ref_clk = ~i_ref_clk;

  gtp_timer_pair gtp_timer_pair_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rdata(o_rdata), .i_timer_gate_count_pin(gate_pins),
    .i_timer_direction_pin(dir_pins), .i_capture_trigger_pin(cap),
    .o_toggle_output_pin(o_toggle_output_pin),
    .o_second_toggle_output_pin(o_second_toggle_output_pin),
    .o_second_core_ovf(o_second_core_ovf), .o_irq(o_irq));

  gtp_sensor_model gtp_sensor_model_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_step(step), .i_rev(rev),
    .o_a(sens_a), .o_b(sens_b));

  function automatic logic [15:0] cv(input logic [2:0] m,
      input logic [2:0] s, input logic [3:0] f);
    return {5'h00, f, 1'b1, m, s};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1 d = o_rdata;
  endtask

  // index 5 stands for the capture pin
  task automatic pulse(input int idx);
    @(posedge i_ref_clk);
    if (idx == 5) cap <= 1'b1;
    else gc[idx] <= 1'b1;
    seen_ovf = 1'b0;
    repeat (3) begin
      @(posedge i_ref_clk);
      #1 if (o_second_core_ovf === 1'b1) seen_ovf = 1'b1;
    end
    @(posedge i_ref_clk);
    if (idx == 5) cap <= 1'b0;
    else gc[idx] <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask

  task automatic qstep(input logic dn);
    @(posedge i_ref_clk);
    step <= 1'b1;
    rev <= dn;
    @(posedge i_ref_clk);
    step <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // generous bound: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_fail++;
    test_done;
  end

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(`GTP_A_CTL + 4'h1, v);
    chk("ctl reset", v, 16'h0000);
    wr(4'he, 16'hbeef);
    rd(4'he, v);
    chk("unmapped", v, 16'h0000);
    // up and down wraps of the first core in counter mode
    wr(`GTP_A_CTL + 4'h1, cv(`GTP_M_COUNT, 3'h1, 4'b0100));
    wr(`GTP_A_CNT + 4'h1, 16'hffff);
    pulse(1);
    rd(`GTP_A_CNT + 4'h1, v);
    chk("up wrap", v, 16'h0000);
    chk("toggle pin", 16'(o_toggle_output_pin), 16'h0001);
    chk("irq masked", 16'(o_irq), 16'h0000);
    wr(`GTP_A_MASK, 16'h0002);
    #1 chk("irq", 16'(o_irq), 16'h0001);
    rd(`GTP_A_STAT, v);
    chk("wrap flag", v, 16'h0002);
    chk("irq cleared", 16'(o_irq), 16'h0000);
    wr(`GTP_A_CTL + 4'h1, cv(`GTP_M_COUNT, 3'h1, 4'b0101));
    wr(`GTP_A_CNT + 4'h1, 16'h0000);
    pulse(1);
    rd(`GTP_A_CNT + 4'h1, v);
    chk("down wrap", v, 16'hffff);
    chk("toggle back", 16'(o_toggle_output_pin), 16'h0000);
    // direction pin reverses an up counter
    wr(`GTP_A_CTL, cv(`GTP_M_COUNT, 3'h1, 4'b0010));
    wr(`GTP_A_CNT, 16'h0010);
    @(posedge i_ref_clk) dp[0] <= 1'b1;
    for (int i = 0; i < 3; i++) pulse(0);
    rd(`GTP_A_CNT, v);
    chk("ext dir count", v, 16'h000d);
    @(posedge i_ref_clk) dp[0] <= 1'b0;
    // gate high active, divide by 8: 80 open cycles give 10 ticks
    wr(`GTP_A_CTL, cv(`GTP_M_GATEHI, 3'h0, 4'b0000));
    wr(`GTP_A_CNT, 16'h0000);
    repeat (40) @(posedge i_ref_clk);
    rd(`GTP_A_CNT, v);
    chk("gate closed", v, 16'h0000);
    @(posedge i_ref_clk) gc[0] <= 1'b1;
    repeat (80) @(posedge i_ref_clk);
    gc[0] <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    rd(`GTP_A_CNT, v);
    chk("gate open", v, 16'h000a);
    // low active gate: pin held high closes it while reconfiguring
    @(posedge i_ref_clk) gc[0] <= 1'b1;
    wr(`GTP_A_CTL, cv(`GTP_M_GATELO, 3'h0, 4'b0000));
    wr(`GTP_A_CNT, 16'h0000);
    @(posedge i_ref_clk) gc[0] <= 1'b0;
    repeat (80) @(posedge i_ref_clk);
    gc[0] <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    rd(`GTP_A_CNT, v);
    chk("gate low open", v, 16'h000a);
    @(posedge i_ref_clk) gc[0] <= 1'b0;
    // free running rates over 80 cycles between paired reads
    wr(`GTP_A_CNT + 4'h2, 16'h0100);
    wr(`GTP_A_CTL + 4'h4, cv(`GTP_M_TIMER, 3'h0, 4'b0000));
    wr(`GTP_A_CTL + 4'h2, cv(`GTP_M_TIMER, 3'h1, 4'b0001));
    rd(`GTP_A_CNT + 4'h4, r[0]);
    rd(`GTP_A_CNT + 4'h2, r[1]);
    repeat (76) @(posedge i_ref_clk);
    rd(`GTP_A_CNT + 4'h4, r[2]);
    rd(`GTP_A_CNT + 4'h2, r[3]);
    chk("div 4 rate", r[2] - r[0], 16'h0014);
    chk("div 16 down", r[1] - r[3], 16'h0005);
    // quadrature tracking with capture on core pin change
    wr(`GTP_A_CTL + 4'h3, cv(3'h7, 3'h0, 4'b0000));
    wr(`GTP_A_CNT + 4'h3, 16'h1234);
    wr(`GTP_A_CAPCTL, 16'h0008);
    wr(`GTP_A_CTL + 4'h1, cv(`GTP_M_INCR, 3'h0, 4'b0000));
    wr(`GTP_A_CNT + 4'h1, 16'h0000);
    for (int i = 0; i < 5; i++) qstep(1'b0);
    for (int i = 0; i < 2; i++) qstep(1'b1);
    rd(`GTP_A_CNT + 4'h1, v);
    chk("position", v, 16'h0003);
    rd(`GTP_A_CAPTURE_RELOAD_REG, v);
    chk("pin capture", v, 16'h1234);
    rd(`GTP_A_STAT, v);
    chk("pin capture flag", v & 16'h0080, 16'h0080);
    // capture pin with clear of the second aux
    wr(`GTP_A_CAPCTL, 16'h0005);
    wr(`GTP_A_CNT + 4'h3, 16'h0777);
    pulse(5);
    rd(`GTP_A_CAPTURE_RELOAD_REG, v);
    chk("capreg", v, 16'h0777);
    rd(`GTP_A_CNT + 4'h3, v);
    chk("aux cleared", v, 16'h0000);
    rd(`GTP_A_STAT, v);
    chk("capreg flag", v & 16'h0080, 16'h0080);
    // reload from aux b, capture into aux a
    wr(`GTP_A_CTL + 4'h1, cv(3'h7, 3'h0, 4'b0000));
    wr(`GTP_A_CTL + 4'h2, cv(`GTP_M_RELOAD, 3'h1, 4'b0000));
    wr(`GTP_A_CNT + 4'h2, 16'h5555);
    pulse(2);
    rd(`GTP_A_CNT + 4'h1, v);
    chk("pin reload", v, 16'h5555);
    wr(`GTP_A_CTL, cv(`GTP_M_CAPT, 3'h1, 4'b0000));
    pulse(0);
    rd(`GTP_A_CNT, v);
    chk("aux capture", v, 16'h5555);
    rd(`GTP_A_CNT + 4'h2, v);
    chk("aux stopped", v, 16'h5555);
    // latch rise loads aux a, fall loads aux b: 16 high, 24 low cycles
    wr(`GTP_A_CNT, 16'hfffe);
    wr(`GTP_A_CNT + 4'h2, 16'hfffd);
    wr(`GTP_A_CTL, cv(`GTP_M_RELOAD, `GTP_SEL_LATRISE, 4'b0000));
    wr(`GTP_A_CTL + 4'h2, cv(`GTP_M_RELOAD, `GTP_SEL_LATFALL, 4'b0000));
    wr(`GTP_A_CNT + 4'h1, 16'hffff);
    wr(`GTP_A_CTL + 4'h1, cv(`GTP_M_TIMER, 3'h0, 4'b0100));
    repeat (16) @(posedge i_ref_clk);
    hi = 0;
    repeat (80) begin
      @(posedge i_ref_clk);
      #1 if (o_toggle_output_pin === 1'b1) hi++;
    end
    chk("pwm high", 16'(hi), 16'h0020);
    // second core wrap reloads from capreg and exports overflow
    wr(`GTP_A_CTL + 4'h4, cv(`GTP_M_COUNT, 3'h1, 4'b1100));
    wr(`GTP_A_CNT + 4'h4, 16'hffff);
    wr(`GTP_A_CTL + 4'h3, cv(`GTP_M_COUNT, 3'h4, 4'b0000));
    pulse(4);
    chk("ovf pulse", 16'(seen_ovf), 16'h0001);
    rd(`GTP_A_CNT + 4'h4, v);
    chk("capreg reload", v, 16'h0777);
    chk("toggle two", 16'(o_second_toggle_output_pin), 16'h0001);
    rd(`GTP_A_CNT + 4'h3, v);
    chk("chained aux", v, 16'h0001);
    test_done;
  end
endmodule
`default_nettype wire
